// ---- hdl/pdm_pkg.sv ----
// Function
// [R1] halt enters sleep when standby_select is 0, software standby when 1
// [R2] standby_select stays 1 after standby exit; only a software write of 0 clears it (code: reset and hardware standby also clear it)
// [R3] wait_time_select picks 8192..131072 settle states; 11x is illegal
// [R4] software should pick a wait of at least 8 ms with a crystal
// [R5] sleep halts cpu, keeps registers; transfer engine, refresh, peripherals run
// [R6] enabled unmasked interrupt ends sleep; disabled or masked ones do not
// [R7] low chip_init_pin_n in sleep goes straight to reset state
// [R8] software standby halts clocks, resets engine and peripherals, keeps cpu and ram
// [R9] standby entry initialises refresh_counter and control bits 7 and 6
// [R10] nmi or irq wake starts oscillator, waits settle count, then interrupt handling
// [R11] irq with enable cleared or cpu mask set does not end software standby
// [R12] reset pin low in standby clocks at once; reset handling on its rise
// [R13] nonmaskable_edge_select picks falling edge when 0, rising edge when 1
// [R14] ports hold their states during software standby
// [R15] low hw_standby_pin_n forces hardware standby, resets all but ram, ports float
// [R16] software clears internal_memory_enable before hardware standby to keep ram
// [R17] boot_mode_pins must stay unchanged during hardware standby
// [R18] standby pin rise with reset low starts oscillator; reset rise starts execution
// [R19] outside drives reset low before standby low; exits standby then reset
// [R20] settle counter counts clocks from restart, releases clock at selected count
package pdm_pkg;
	localparam logic [1:0] ADDR_SYSCTL   = 2'h0;
	localparam logic [1:0] ADDR_STATUS   = 2'h1;
	localparam int         BIT_SSEL      = 7;
	localparam int         BIT_WAIT_HI   = 6;
	localparam int         BIT_WAIT_LO   = 4;
	localparam int         BIT_NMIEDGE   = 2;
	localparam int         BIT_MEMEN     = 0;
	localparam logic [7:0] SYSCTL_RESET  = 8'h0b;
	localparam int         SETTLE_BASE   = 8192;
	localparam int         IRQ_COUNT     = 3;
	typedef enum logic [2:0] {
		PDM_RUN      = 3'b000,
		PDM_SLEEP    = 3'b001,
		PDM_SWSTBY   = 3'b010,
		PDM_SETTLE   = 3'b011,
		PDM_RESET    = 3'b100,
		PDM_HWSTBY   = 3'b101
	} pdm_state_t;
endpackage : pdm_pkg

// ---- hdl/pdm_settle_counter.sv ----
`timescale 1ns/1ps
module pdm_settle_counter #(
	parameter int BASE = pdm_pkg::SETTLE_BASE
) (
	input  wire logic       ref_clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       start_in,
	input  wire logic [2:0] sel_in,
	output logic            done_out
);
	import pdm_pkg::*;
	typedef struct packed {
		logic        run;
		logic [17:0] cnt;
		logic        done;
	} pdm_cnt_t;
	pdm_cnt_t st;
	pdm_cnt_t next_st;
	logic [17:0] limit;

	// 10x both mean 131072; 11x is illegal and treated the same
	always_comb begin
		if (sel_in[2]) begin
			limit = 18'(BASE * 16);
		end else begin
			limit = 18'(BASE) << sel_in[1:0]; // R3
		end
	end

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (start_in) begin
			next_st.run = 1'b1;
			next_st.cnt = 18'h00001;
		end else if (st.run) begin
			if (st.cnt >= limit) begin
				next_st.run = 1'b0;
				next_st.done = 1'b1; // R20
			end else begin
				next_st.cnt = st.cnt + 18'h00001; // R20
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done_out = st.done;

	a_done_pulse: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		st.done |=> !st.done) else $error("settle done not a pulse"); // R20
endmodule : pdm_settle_counter

// ---- hdl/pdm_power_ctrl.sv ----
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module pdm_power_ctrl (
	input  wire logic                          ref_clk_in,
	input  wire logic                          arst_n_in,
	input  wire logic [1:0]                    addr_in,
	input  wire logic [7:0]                    wdata_in,
	input  wire logic                          wr_in,
	input  wire logic                          rd_in,
	output logic [7:0]                         rdata_out,
	input  wire logic                          halt_exec_in,
	input  wire logic                          periph_irq_in,
	input  wire logic                          periph_irq_en_in,
	input  wire logic                          cpu_mask_in,
	input  wire logic                          nmi_pin_in,
	input  wire logic [pdm_pkg::IRQ_COUNT-1:0] external_interrupt_pins_in,
	input  wire logic [pdm_pkg::IRQ_COUNT-1:0] irq_enable_in,
	input  wire logic                          chip_init_pin_n_in,
	input  wire logic                          hw_standby_pin_n_in,
	output logic                               cpu_halt_out,
	output logic                               sys_clk_en_out,
	output logic                               osc_run_out,
	output logic                               periph_run_out,
	output logic                               periph_reset_out,
	output logic                               refresh_init_out,
	output logic                               ports_hold_out,
	output logic                               ports_float_out,
	output logic                               irq_entry_out,
	output logic                               reset_entry_out,
	output logic                               nmi_flag_out
);
	import pdm_pkg::*;
	typedef struct packed {
		pdm_state_t state;
		logic [7:0] sysctl;
		logic       nmi_prev;
		logic       cpu_halt;
		logic       clk_en;
		logic       osc_run;
		logic       p_run;
		logic       p_rst;
		logic       rf_init;
		logic       hold;
		logic       flt;
		logic       irq_ent;
		logic       rst_ent;
		logic       nmi_flag;
		logic [7:0] rdata;
	} pdm_ctrl_t;
	pdm_ctrl_t st;
	pdm_ctrl_t next_st;
	logic      nmi_edge;
	logic      irq_wake;
	logic      sleep_wake;
	logic      settle_start;
	logic      settle_done;

	////////////////////////////////////////////////////////////////////////
	// wake sources
	always_comb begin
		// edge select: 0 falling, 1 rising
		if (st.sysctl[BIT_NMIEDGE]) begin
			nmi_edge = nmi_pin_in & ~st.nmi_prev; // R13
		end else begin
			nmi_edge = ~nmi_pin_in & st.nmi_prev; // R13
		end
		// irq pins are active low; enable off or cpu mask blocks wake
		irq_wake = |(~external_interrupt_pins_in & irq_enable_in)
			& ~cpu_mask_in; // R11
		sleep_wake = nmi_edge | irq_wake
			| (periph_irq_in & periph_irq_en_in & ~cpu_mask_in); // R6
	end

	assign settle_start = (st.state == PDM_SWSTBY) && chip_init_pin_n_in
		&& hw_standby_pin_n_in && (nmi_edge || irq_wake); // R10

	pdm_settle_counter #(
		.BASE(SETTLE_BASE)
	) u_settle (
		.ref_clk_in (ref_clk_in),
		.arst_n_in  (arst_n_in),
		.start_in   (settle_start),
		.sel_in     (st.sysctl[BIT_WAIT_HI:BIT_WAIT_LO]),
		.done_out   (settle_done)
	);

	////////////////////////////////////////////////////////////////////////
	// state machine and register file
	always_comb begin
		next_st = st;
		next_st.nmi_prev = nmi_pin_in;
		next_st.irq_ent = 1'b0;
		next_st.rst_ent = 1'b0;
		next_st.rf_init = 1'b0;
		next_st.rdata = 8'h00;
		if (nmi_edge) begin
			next_st.nmi_flag = 1'b1;
		end
		if (wr_in && addr_in == ADDR_SYSCTL) begin
			// standby_select changes through this write or a load of SYSCTL_RESET in reset or hardware standby
			next_st.sysctl = wdata_in; // R2
		end else if (wr_in && addr_in == ADDR_STATUS && wdata_in[0]) begin
			next_st.nmi_flag = nmi_edge;
		end
		if (rd_in) begin
			case (addr_in)
				ADDR_SYSCTL: begin
					next_st.rdata = st.sysctl;
				end
				ADDR_STATUS: begin
					next_st.rdata = {4'h0, st.nmi_flag, st.state};
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end
		if (!hw_standby_pin_n_in) begin
			// everything but on-chip memory resets, ports float
			next_st.state = PDM_HWSTBY; // R15
			next_st.sysctl = SYSCTL_RESET; // R15
			next_st.nmi_flag = 1'b0;
		end else begin
			case (st.state)
				PDM_RUN: begin
					if (!chip_init_pin_n_in) begin
						next_st.state = PDM_RESET;
					end else if (halt_exec_in) begin
						if (st.sysctl[BIT_SSEL]) begin
							next_st.state = PDM_SWSTBY; // R1
							next_st.rf_init = 1'b1; // R9
						end else begin
							next_st.state = PDM_SLEEP; // R1
						end
					end
				end
				PDM_SLEEP: begin
					if (!chip_init_pin_n_in) begin
						next_st.state = PDM_RESET; // R7
					end else if (sleep_wake) begin
						next_st.state = PDM_RUN; // R6
						next_st.irq_ent = 1'b1; // R6
					end
				end
				PDM_SWSTBY: begin
					if (!chip_init_pin_n_in) begin
						next_st.state = PDM_RESET; // R12
					end else if (settle_start) begin
						next_st.state = PDM_SETTLE; // R10
					end
				end
				PDM_SETTLE: begin
					if (!chip_init_pin_n_in) begin
						next_st.state = PDM_RESET;
					end else if (settle_done) begin
						next_st.state = PDM_RUN; // R20
						next_st.irq_ent = 1'b1; // R10
					end
				end
				PDM_RESET: begin
					next_st.sysctl = SYSCTL_RESET;
					if (chip_init_pin_n_in) begin
						next_st.state = PDM_RUN; // R18
						next_st.rst_ent = 1'b1; // R12
					end
				end
				PDM_HWSTBY: begin
					// pin rises: oscillator runs while reset held low
					next_st.state = PDM_RESET; // R18
				end
				default: begin
					next_st.state = PDM_RUN;
				end
			endcase
		end
		case (next_st.state)
			PDM_RUN: begin
				{next_st.cpu_halt, next_st.clk_en, next_st.osc_run} = 3'b011;
				{next_st.p_run, next_st.p_rst} = 2'b10;
				{next_st.hold, next_st.flt} = 2'b00;
			end
			PDM_SLEEP: begin
				{next_st.cpu_halt, next_st.clk_en, next_st.osc_run} = 3'b111;
				{next_st.p_run, next_st.p_rst} = 2'b10; // R5
				{next_st.hold, next_st.flt} = 2'b00;
			end
			PDM_SWSTBY: begin
				{next_st.cpu_halt, next_st.clk_en, next_st.osc_run} = 3'b100;
				{next_st.p_run, next_st.p_rst} = 2'b01; // R8
				{next_st.hold, next_st.flt} = 2'b10; // R14
			end
			PDM_SETTLE: begin
				{next_st.cpu_halt, next_st.clk_en, next_st.osc_run} = 3'b101;
				{next_st.p_run, next_st.p_rst} = 2'b01;
				{next_st.hold, next_st.flt} = 2'b10; // R14
			end
			PDM_RESET: begin
				// clocks supplied at once while reset held
				{next_st.cpu_halt, next_st.clk_en, next_st.osc_run} = 3'b111;
				{next_st.p_run, next_st.p_rst} = 2'b01; // R12
				{next_st.hold, next_st.flt} = 2'b00;
			end
			default: begin
				{next_st.cpu_halt, next_st.clk_en, next_st.osc_run} = 3'b100;
				{next_st.p_run, next_st.p_rst} = 2'b01;
				{next_st.hold, next_st.flt} = 2'b01; // R15
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= '{state: PDM_RESET, sysctl: SYSCTL_RESET, nmi_prev: 1'b1,
				cpu_halt: 1'b1, clk_en: 1'b1, osc_run: 1'b1, p_run: 1'b0,
				p_rst: 1'b1, rf_init: 1'b0, hold: 1'b0, flt: 1'b0,
				irq_ent: 1'b0, rst_ent: 1'b0, nmi_flag: 1'b0,
				rdata: 8'h00};
		end else begin
			st <= next_st;
		end
	end

	assign rdata_out        = st.rdata;
	assign cpu_halt_out     = st.cpu_halt;
	assign sys_clk_en_out   = st.clk_en;
	assign osc_run_out      = st.osc_run;
	assign periph_run_out   = st.p_run;
	assign periph_reset_out = st.p_rst;
	assign refresh_init_out = st.rf_init;
	assign ports_hold_out   = st.hold;
	assign ports_float_out  = st.flt;
	assign irq_entry_out    = st.irq_ent;
	assign reset_entry_out  = st.rst_ent;
	assign nmi_flag_out     = st.nmi_flag;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_halt_run;
		st.state == PDM_RUN && halt_exec_in && chip_init_pin_n_in
			&& hw_standby_pin_n_in;
	endsequence

	a_halt_sleep: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		s_halt_run and !st.sysctl[BIT_SSEL] |=> st.state == PDM_SLEEP)
		else $error("halt did not enter sleep"); // R1
	a_halt_swstby: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		s_halt_run and st.sysctl[BIT_SSEL] |=> st.state == PDM_SWSTBY
		&& refresh_init_out) else $error("standby entry wrong"); // R9
	a_ssel_keep: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!wr_in && hw_standby_pin_n_in && st.state != PDM_RESET
		|=> st.sysctl[BIT_SSEL] == $past(st.sysctl[BIT_SSEL]))
		else $error("standby select changed"); // R2
	a_sleep_run: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		st.state == PDM_SLEEP |-> periph_run_out && cpu_halt_out)
		else $error("sleep outputs wrong"); // R5
	a_sleep_rst: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		st.state == PDM_SLEEP && !chip_init_pin_n_in && hw_standby_pin_n_in
		|=> st.state == PDM_RESET) else $error("sleep reset exit"); // R7
	a_masked_irq: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		st.state == PDM_SWSTBY && cpu_mask_in && !nmi_edge
		&& chip_init_pin_n_in && hw_standby_pin_n_in
		|=> st.state == PDM_SWSTBY) else $error("masked irq woke"); // R11
	a_hw_hw_standby_pin_n: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!hw_standby_pin_n_in |=> st.state == PDM_HWSTBY ##0 ports_float_out
		##0 periph_reset_out) else $error("hardware standby"); // R15
	a_swstby_hold: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		st.state == PDM_SWSTBY |-> ports_hold_out && !sys_clk_en_out
		&& periph_reset_out) else $error("software standby out"); // R14
	a_wake_irq: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		st.state == PDM_SETTLE && settle_done && chip_init_pin_n_in
		&& hw_standby_pin_n_in |=> irq_entry_out && st.state == PDM_RUN)
		else $error("settle exit"); // R10
endmodule : pdm_power_ctrl

// ---- test/pdm_pin_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// drives the init, standby and interrupt pins from outside the chip
module pdm_pin_model (
	input  wire logic       ref_clk_in,
	output logic            chip_init_pin_n_out,
	output logic            hw_standby_pin_n_out,
	output logic            nmi_pin_out,
	output logic [2:0]      irq_pins_n_out
);
	// mode pins are not modelled, so they never move in hardware standby
	initial begin
		chip_init_pin_n_out  = 1'b0;
		hw_standby_pin_n_out = 1'b1;
		nmi_pin_out          = 1'b0;
		irq_pins_n_out       = 3'h7;
	end
	////////////////////////////////////////////////////////////////////////
	// init pin held low for hold clock cycles, then driven high
	task automatic init_low(input int hold);
		@(posedge ref_clk_in) chip_init_pin_n_out <= 1'b0;
		repeat (hold) @(posedge ref_clk_in);
		chip_init_pin_n_out <= 1'b1;
	endtask : init_low
	// init low before standby low; standby high, settle, then init high
	task automatic hw_standby(input int hold);
		@(posedge ref_clk_in) chip_init_pin_n_out <= 1'b0;
		@(posedge ref_clk_in) hw_standby_pin_n_out <= 1'b0;
		repeat (hold) @(posedge ref_clk_in);
		hw_standby_pin_n_out <= 1'b1;
		repeat (hold) @(posedge ref_clk_in);
		chip_init_pin_n_out <= 1'b1;
	endtask : hw_standby
	task automatic set_ints(input logic nmi, input logic [2:0] irq_n);
		@(posedge ref_clk_in) begin
			nmi_pin_out    <= nmi;
			irq_pins_n_out <= irq_n;
		end
	endtask : set_ints
endmodule : pdm_pin_model

// ---- test/tb_power_down_mode_control.sv ----
`timescale 1ns/1ps
module tb_power_down_mode_control;
	import pdm_pkg::*;
	typedef struct {logic [1:0] a; logic [7:0] v; logic [7:0] e;} pdm_row_t;
	logic       ref_clk_in = 1'b0;
	logic       arst_n_in = 1'b0;
	logic [1:0] addr_in = 2'h0;
	logic [7:0] wdata_in = 8'h00;
	logic       wr_in = 1'b0, rd_in = 1'b0, halt_in = 1'b0;
	logic       p_irq = 1'b0, p_irq_en = 1'b0, mask = 1'b0;
	logic [2:0] irq_en = 3'h0, irq_n;
	logic       nmi, init_n, hw_standby_pin_n_n, cpu_halt, clk_en, osc, p_run, p_rst;
	logic       rfi, hold, flt, irq_e, rst_e;
	logic [7:0] rdata, d;
	int         err_count = 0, samples_checked = 0;
	int         n_irq = 0, n_rst = 0, n_rfi = 0;
	pdm_row_t   rows[4] = '{'{ADDR_SYSCTL, 8'hf5, 8'hf5},
		'{ADDR_SYSCTL, 8'h74, 8'h74}, '{2'h2, 8'hff, 8'h00},
		'{2'h3, 8'h5a, 8'h00}};
	always #5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) begin
		if (irq_e === 1'b1) n_irq <= n_irq + 1;
		if (rst_e === 1'b1) n_rst <= n_rst + 1;
		if (rfi === 1'b1) n_rfi <= n_rfi + 1;
	end
	pdm_power_ctrl u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata), .halt_exec_in(halt_in), .periph_irq_in(p_irq),
		.periph_irq_en_in(p_irq_en), .cpu_mask_in(mask), .nmi_pin_in(nmi),
		.external_interrupt_pins_in(irq_n), .irq_enable_in(irq_en),
		.chip_init_pin_n_in(init_n), .hw_standby_pin_n_in(hw_standby_pin_n_n),
		.cpu_halt_out(cpu_halt), .sys_clk_en_out(clk_en), .osc_run_out(osc),
		.periph_run_out(p_run), .periph_reset_out(p_rst),
		.refresh_init_out(rfi), .ports_hold_out(hold), .ports_float_out(flt),
		.irq_entry_out(irq_e), .reset_entry_out(rst_e), .nmi_flag_out());
	pdm_pin_model u_pins (.ref_clk_in(ref_clk_in),
		.chip_init_pin_n_out(init_n), .hw_standby_pin_n_out(hw_standby_pin_n_n),
		.nmi_pin_out(nmi), .irq_pins_n_out(irq_n));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge ref_clk_in) begin
			addr_in  <= a;
			wdata_in <= v;
			wr_in    <= 1'b1;
		end
		@(posedge ref_clk_in) wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a);
		@(posedge ref_clk_in) begin
			addr_in <= a;
			rd_in   <= 1'b1;
		end
		@(posedge ref_clk_in) rd_in <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic state_is(input pdm_state_t s, input string m);
		rd(ADDR_STATUS);
		chk({5'h0, d[2:0]}, {5'h0, s}, m);
	endtask : state_is
	task automatic halt();
		@(posedge ref_clk_in) halt_in <= 1'b1;
		@(posedge ref_clk_in) halt_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
	endtask : halt
	// counts edges until interrupt entry, bounded past the settle count
	task automatic wake(input int n, input string m);
		int c0;
		int t;
		c0 = n_irq;
		t = 0;
		while (n_irq == c0 && t < n + 20) begin
			@(posedge ref_clk_in);
			t++;
		end
		chk({7'h0, t >= n && t <= n + 5}, 8'h01, m);
	endtask : wake
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////
	initial begin
		#1ms;
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		summarize();
	end
	initial begin
		repeat (16) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		u_pins.init_low(4);
		repeat (4) @(posedge ref_clk_in);
		rd(ADDR_SYSCTL);
		chk(d, SYSCTL_RESET, "sysctl reset");
		state_is(PDM_RUN, "run after reset");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].v);
			rd(rows[i].a);
			chk(d & (rows[i].a == ADDR_SYSCTL ? 8'hf5 : 8'hff), rows[i].e,
				"reg row");
		end
		$display("test registers done");
		wr(ADDR_SYSCTL, 8'h00);
		halt();
		state_is(PDM_SLEEP, "sleep");
		chk({4'h0, cpu_halt, clk_en, p_run, p_rst}, 8'h0e, "sleep out");
		@(posedge ref_clk_in) p_irq <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		state_is(PDM_SLEEP, "disabled irq");
		@(posedge ref_clk_in) begin
			p_irq_en <= 1'b1;
			mask     <= 1'b1;
		end
		repeat (4) @(posedge ref_clk_in);
		state_is(PDM_SLEEP, "masked irq");
		@(posedge ref_clk_in) mask <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		state_is(PDM_RUN, "sleep wake");
		chk(8'(n_irq), 8'h01, "irq entry");
		@(posedge ref_clk_in) p_irq <= 1'b0;
		halt();
		u_pins.init_low(8);
		repeat (4) @(posedge ref_clk_in);
		chk(8'(n_rst), 8'h02, "sleep reset");
		$display("test sleep done");
		wr(ADDR_SYSCTL, 8'h80);
		halt();
		state_is(PDM_SWSTBY, "standby");
		chk({4'h0, clk_en, p_rst, hold, 1'b0}, 8'h06, "standby out");
		chk(8'(n_rfi), 8'h01, "refresh init");
		u_pins.set_ints(1'b0, 3'h6);
		repeat (4) @(posedge ref_clk_in);
		state_is(PDM_SWSTBY, "irq disabled");
		@(posedge ref_clk_in) begin
			irq_en <= 3'h1;
			mask   <= 1'b1;
		end
		repeat (4) @(posedge ref_clk_in);
		state_is(PDM_SWSTBY, "irq masked");
		@(posedge ref_clk_in) mask <= 1'b0;
		wake(SETTLE_BASE, "irq settle");
		rd(ADDR_SYSCTL);
		chk({7'h0, d[7]}, 8'h01, "select kept");
		u_pins.set_ints(1'b0, 3'h7);
		// simulated clock counts as external, so any wait is allowed
		wr(ADDR_SYSCTL, 8'h90);
		halt();
		u_pins.set_ints(1'b0, 3'h6);
		wake(2 * SETTLE_BASE, "settle x2");
		u_pins.set_ints(1'b0, 3'h7);
		wr(ADDR_SYSCTL, 8'h84);
		halt();
		u_pins.set_ints(1'b1, 3'h7);
		wake(SETTLE_BASE, "nmi rise");
		wr(ADDR_SYSCTL, 8'h80);
		halt();
		u_pins.set_ints(1'b0, 3'h7);
		wake(SETTLE_BASE, "nmi fall");
		halt();
		fork
			u_pins.init_low(8);
			begin
				repeat (3) @(posedge ref_clk_in);
				#1 chk({7'h0, clk_en}, 8'h01, "clock at once");
			end
		join
		repeat (4) @(posedge ref_clk_in);
		chk(8'(n_rst), 8'h03, "standby reset");
		$display("test software standby done");
		wr(ADDR_SYSCTL, 8'h00);
		halt();
		fork
			u_pins.hw_standby(10);
			begin
				repeat (5) @(posedge ref_clk_in);
				#1 chk({7'h0, flt}, 8'h01, "ports float");
				state_is(PDM_HWSTBY, "hw standby");
			end
		join
		repeat (4) @(posedge ref_clk_in);
		state_is(PDM_RUN, "hw exit");
		chk(8'(n_rst), 8'h04, "hw reset entry");
		rd(ADDR_SYSCTL);
		chk(d, SYSCTL_RESET, "hw sysctl");
		$display("test hardware standby done");
		summarize();
	end
endmodule : tb_power_down_mode_control
